/* design/ser_pkg.sv */
// package for the status event register groups: register selects, widths, preset values
//Contract
//- each condition part mirrors the live hardware status and reading it changes nothing.
//- each event part keeps every bit caught since the last read, and a read returns it and then clears it.
//- a low-to-high condition change whose rising filter bit is one sets the event bit.
//- a high-to-low condition change whose falling filter bit is one sets the event bit.
//- the group summary is high whenever any event bit is set together with its mask bit.
//- a rising edge of a group summary is passed upward as a one-cycle positive transition pulse.
//- every register part is 15 bits wide and accepts or returns 0 to 32767.
//- a preset loads every rising filter with all ones.
//- a preset clears every falling filter.
//- a preset clears both enable masks.
//- the general instrument reset command leaves every status register part unchanged.
`default_nettype none
package ser_pkg;
    localparam int SER_WIDTH = 15;
    localparam logic [SER_WIDTH-1:0] SER_ALL_ONES = 15'h7FFF;
    localparam logic [SER_WIDTH-1:0] SER_ZERO = 15'h0000;
    // values after reset
    localparam logic [SER_WIDTH-1:0] SER_RISE_RESET = 15'h7FFF;
    localparam logic [SER_WIDTH-1:0] SER_FALL_RESET = 15'h0000;
    localparam logic [SER_WIDTH-1:0] SER_MASK_RESET = 15'h0000;
    localparam logic [SER_WIDTH-1:0] SER_LATCH_RESET = 15'h0000;

    // register part select on the access port
    typedef enum logic [3:0] {
        SER_OP_COND = 4'h0,
        SER_OP_MASK = 4'h1,
        SER_OP_LATCH = 4'h2,
        SER_OP_FALL = 4'h3,
        SER_OP_RISE = 4'h4,
        SER_QU_COND = 4'h8,
        SER_QU_MASK = 4'h9,
        SER_QU_LATCH = 4'hA,
        SER_QU_FALL = 4'hB,
        SER_QU_RISE = 4'hC
    } ser_sel_type;

    // one access request from the command side
    typedef struct packed {
        logic rd;
        logic wr;
        ser_sel_type sel;
        logic [SER_WIDTH-1:0] wdata;
    } ser_req_type;

    // one group's register state
    typedef struct packed {
        logic [SER_WIDTH-1:0] rise;
        logic [SER_WIDTH-1:0] fall;
        logic [SER_WIDTH-1:0] mask;
        logic [SER_WIDTH-1:0] latch;
    } ser_group_type;
endpackage
`default_nettype wire

/* design/ser_status_groups.sv */
// operation and questionable status groups with transition filters, latches and summaries
`default_nettype none
module ser_status_groups
    import ser_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // live hardware status, from outside this clock domain
    input wire logic [SER_WIDTH-1:0] opCondIn,
    input wire logic [SER_WIDTH-1:0] quCondIn,
    // register access and preset command
    input wire ser_req_type req,
    input wire logic presetReq,
    output logic [SER_WIDTH-1:0] rdData,
    output logic rdValid,
    // summaries toward the status byte
    output logic opSummary,
    output logic quSummary,
    output logic opSummaryRise,
    output logic quSummaryRise
);
    logic [SER_WIDTH-1:0] opSync1_reg, opSync2_reg, quSync1_reg, quSync2_reg;
    logic [SER_WIDTH-1:0] opPrev_reg, quPrev_reg;
    ser_group_type op_reg, qu_reg;
    logic [SER_WIDTH-1:0] opHit, quHit;

    // edge filter, shared by both groups
    function automatic logic [SER_WIDTH-1:0] edgeHits(input logic [SER_WIDTH-1:0] now,
        input logic [SER_WIDTH-1:0] prev, input ser_group_type g);
        edgeHits = (now & ~prev & g.rise) | (~now & prev & g.fall);
    endfunction

    // next latch value: read clears, but a fresh edge wins over the clear
    function automatic logic [SER_WIDTH-1:0] latchNext(input logic [SER_WIDTH-1:0] cur,
        input logic [SER_WIDTH-1:0] hit, input logic clr);
        latchNext = (clr ? SER_ZERO : cur) | hit;
    endfunction

    // two-stage synchronisers; second stage is the visible condition part
    always_ff @(posedge mclk)
    begin
        opSync1_reg <= opCondIn;
        opSync2_reg <= opSync1_reg;
        quSync1_reg <= quCondIn;
        quSync2_reg <= quSync1_reg;
    end

    // previous condition for edge detection; reset loads zero so a bit high at start counts
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            opPrev_reg <= SER_ZERO;
            quPrev_reg <= SER_ZERO;
        end
        else
        begin
            opPrev_reg <= opSync2_reg;
            quPrev_reg <= quSync2_reg;
        end
    end

    assign opHit = edgeHits(opSync2_reg, opPrev_reg, op_reg);
    assign quHit = edgeHits(quSync2_reg, quPrev_reg, qu_reg);

    // operation group state; only the power-on reset touches it, no command reset here
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            op_reg <= '{SER_RISE_RESET, SER_FALL_RESET, SER_MASK_RESET, SER_LATCH_RESET};
        else
        begin
            op_reg.latch <= latchNext(op_reg.latch, opHit, req.rd && req.sel == SER_OP_LATCH);
            if (presetReq)
            begin
                op_reg.rise <= SER_ALL_ONES;
                op_reg.fall <= SER_ZERO;
                op_reg.mask <= SER_ZERO;
            end
            else if (req.wr)
            begin
                if (req.sel == SER_OP_RISE)
                    op_reg.rise <= req.wdata;
                if (req.sel == SER_OP_FALL)
                    op_reg.fall <= req.wdata;
                if (req.sel == SER_OP_MASK)
                    op_reg.mask <= req.wdata;
            end
        end
    end

    // questionable group state, same structure
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            qu_reg <= '{SER_RISE_RESET, SER_FALL_RESET, SER_MASK_RESET, SER_LATCH_RESET};
        else
        begin
            qu_reg.latch <= latchNext(qu_reg.latch, quHit, req.rd && req.sel == SER_QU_LATCH);
            if (presetReq)
            begin
                qu_reg.rise <= SER_ALL_ONES;
                qu_reg.fall <= SER_ZERO;
                qu_reg.mask <= SER_ZERO;
            end
            else if (req.wr)
            begin
                if (req.sel == SER_QU_RISE)
                    qu_reg.rise <= req.wdata;
                if (req.sel == SER_QU_FALL)
                    qu_reg.fall <= req.wdata;
                if (req.sel == SER_QU_MASK)
                    qu_reg.mask <= req.wdata;
            end
        end
    end

    // read data returns the value before any clear of the same cycle
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            rdData <= SER_ZERO;
            rdValid <= 1'b0;
        end
        else
        begin
            rdValid <= req.rd;
            if (req.rd)
            begin
                case (req.sel)
                    SER_OP_COND: rdData <= opSync2_reg;
                    SER_OP_MASK: rdData <= op_reg.mask;
                    SER_OP_LATCH: rdData <= op_reg.latch;
                    SER_OP_FALL: rdData <= op_reg.fall;
                    SER_OP_RISE: rdData <= op_reg.rise;
                    SER_QU_COND: rdData <= quSync2_reg;
                    SER_QU_MASK: rdData <= qu_reg.mask;
                    SER_QU_LATCH: rdData <= qu_reg.latch;
                    SER_QU_FALL: rdData <= qu_reg.fall;
                    SER_QU_RISE: rdData <= qu_reg.rise;
                    default: rdData <= SER_ZERO; // unmapped selects read zero
                endcase
            end
        end
    end

    // summaries registered so outputs come from flops; one cycle behind the latch
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            opSummary <= 1'b0;
            quSummary <= 1'b0;
            opSummaryRise <= 1'b0;
            quSummaryRise <= 1'b0;
        end
        else
        begin
            opSummary <= |(op_reg.latch & op_reg.mask);
            quSummary <= |(qu_reg.latch & qu_reg.mask);
            opSummaryRise <= |(op_reg.latch & op_reg.mask) & ~opSummary;
            quSummaryRise <= |(qu_reg.latch & qu_reg.mask) & ~quSummary;
        end
    end

    // summary levels and their rise pulses, both groups
    a_summary_tracks: assert property (@(posedge mclk) disable iff (sys_rst)
        opSummary == |($past(op_reg.latch) & $past(op_reg.mask)))
        else $error("operation summary does not follow masked latch");
    a_qu_summary_tracks: assert property (@(posedge mclk) disable iff (sys_rst)
        quSummary == |($past(qu_reg.latch) & $past(qu_reg.mask)))
        else $error("questionable summary does not follow masked latch");
    a_summary_pulse: assert property (@(posedge mclk) disable iff (sys_rst)
        $rose(quSummary) |-> quSummaryRise)
        else $error("questionable summary rise not reported");
    a_op_summary_pulse: assert property (@(posedge mclk) disable iff (sys_rst)
        $rose(opSummary) |-> opSummaryRise)
        else $error("operation summary rise not reported");
    // a pulse that stands two cycles would be counted twice upstream
    a_pulse_single: assert property (@(posedge mclk) disable iff (sys_rst)
        opSummaryRise |=> !opSummaryRise)
        else $error("summary rise pulse longer than one cycle");
    // edge filters, bit 0 of each group in each direction
    a_rise_sets_latch: assert property (@(posedge mclk) disable iff (sys_rst)
        (opSync2_reg[0] && !opPrev_reg[0] && op_reg.rise[0]) |=> op_reg.latch[0])
        else $error("rising edge lost");
    a_qu_rise_latch: assert property (@(posedge mclk) disable iff (sys_rst)
        (quSync2_reg[0] && !quPrev_reg[0] && qu_reg.rise[0]) |=> qu_reg.latch[0])
        else $error("questionable rising edge lost");
    a_fall_sets_latch: assert property (@(posedge mclk) disable iff (sys_rst)
        (!quSync2_reg[0] && quPrev_reg[0] && qu_reg.fall[0]) |=> qu_reg.latch[0])
        else $error("falling edge lost");
    a_op_fall_latch: assert property (@(posedge mclk) disable iff (sys_rst)
        (!opSync2_reg[0] && opPrev_reg[0] && op_reg.fall[0]) |=> op_reg.latch[0])
        else $error("operation falling edge lost");
    // read-clear; a hit in the read cycle must win over the clear
    a_read_clears: assert property (@(posedge mclk) disable iff (sys_rst)
        (req.rd && req.sel == SER_OP_LATCH && opHit == SER_ZERO) |=> op_reg.latch == SER_ZERO)
        else $error("event read did not clear");
    a_hit_survives_read: assert property (@(posedge mclk) disable iff (sys_rst)
        (req.rd && req.sel == SER_QU_LATCH) |=> ((qu_reg.latch & $past(quHit)) == $past(quHit)))
        else $error("edge lost on read clear");
    a_latch_sticky: assert property (@(posedge mclk) disable iff (sys_rst)
        (!(req.rd && req.sel == SER_OP_LATCH)) |=> ((op_reg.latch & $past(op_reg.latch))
        == $past(op_reg.latch)))
        else $error("event bit dropped without read");
    // preset reloads filters and masks in every group
    a_preset_values: assert property (@(posedge mclk) disable iff (sys_rst)
        presetReq |=> (op_reg.rise == SER_ALL_ONES && qu_reg.fall == SER_ZERO
        && op_reg.mask == SER_ZERO && qu_reg.mask == SER_ZERO))
        else $error("preset values wrong");
    a_preset_others: assert property (@(posedge mclk) disable iff (sys_rst)
        presetReq |=> (qu_reg.rise == SER_ALL_ONES && op_reg.fall == SER_ZERO))
        else $error("preset filter values wrong");
    // condition readback returns the synchronised level
    a_cond_readback: assert property (@(posedge mclk) disable iff (sys_rst)
        (req.rd && req.sel == SER_OP_COND) |=> rdValid && rdData == $past(opSync2_reg))
        else $error("condition readback wrong");
    a_qu_cond_readback: assert property (@(posedge mclk) disable iff (sys_rst)
        (req.rd && req.sel == SER_QU_COND) |=> rdValid && rdData == $past(quSync2_reg))
        else $error("questionable condition readback wrong");
endmodule
`default_nettype wire

/* dv/testbench.sv */
// self-checking bench for the operation and questionable status groups
`default_nettype none
module testbench
    import ser_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic [SER_WIDTH-1:0] opCondIn = '0;
    logic [SER_WIDTH-1:0] quCondIn = '0;
    ser_req_type req = '0;
    logic presetReq = 1'b0;
    logic [SER_WIDTH-1:0] rdData;
    logic rdValid;
    logic opSummary;
    logic quSummary;
    logic opSummaryRise;
    logic quSummaryRise;
    logic [SER_WIDTH-1:0] expQ[$];
    logic [31:0] seed = 32'hCDB1;
    int n_mismatch = 0;
    int n_compared = 0;
    int riseCnt[2] = '{0, 0};

    ser_status_groups i_dut (.mclk(mclk), .sys_rst(sys_rst), .opCondIn(opCondIn),
        .quCondIn(quCondIn), .req(req), .presetReq(presetReq), .rdData(rdData),
        .rdValid(rdValid), .opSummary(opSummary), .quSummary(quSummary),
        .opSummaryRise(opSummaryRise), .quSummaryRise(quSummaryRise));

    // 125 MHz clock
    initial
    begin
        forever #4 mclk = ~mclk;
    end

    task automatic chk_val(string what, logic [SER_WIDTH-1:0] e, logic [SER_WIDTH-1:0] g);
        n_compared++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic chk_bit(string what, logic e, logic g);
        n_compared++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %b seen %b", what, e, g);
        end
    endtask

    task automatic tally_and_finish();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    function automatic logic [31:0] xs(logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // one access; a read notes its expected answer for the monitor
    task automatic acc(logic r, logic w, bit g, logic [2:0] k, logic [14:0] d, logic [14:0] e);
        @(posedge mclk);
        req <= '{rd: r, wr: w, sel: ser_sel_type'({g, k}), wdata: d};
        if (r)
            expQ.push_back(e);
        @(posedge mclk);
        req <= '0;
    endtask

    task automatic set_cond(bit g, logic [14:0] v);
        @(posedge mclk);
        if (g)
            quCondIn <= v;
        else
            opCondIn <= v;
        repeat (4) @(posedge mclk);
    endtask

    // answers are matched oldest first; a stray rdValid is a mismatch too
    always @(posedge mclk)
    begin
        if (rdValid === 1'b1)
        begin
            if (expQ.size() == 0)
                chk_bit("unexpected rdValid", 1'b0, 1'b1);
            else
                chk_val("rdData", expQ.pop_front(), rdData);
        end
        if (opSummaryRise === 1'b1)
            riseCnt[0]++;
        if (quSummaryRise === 1'b1)
            riseCnt[1]++;
    end

    // watchdog, far beyond the roughly 150 cycles the sequence needs
    initial
    begin
        #(8 * 20000);
        n_mismatch++;
        tally_and_finish();
    end

    initial
    begin
        logic [14:0] v;
        repeat (10) @(posedge mclk);
        sys_rst <= 1'b0;
        for (int g = 0; g < 2; g++)
        begin
            seed = xs(seed);
            v = seed[14:0] | 15'h0001;
            acc(1, 0, g, 3'h4, 15'h0, SER_RISE_RESET);
            acc(1, 0, g, 3'h3, 15'h0, 15'h0000);
            acc(1, 0, g, 3'h1, 15'h0, 15'h0000);
            acc(1, 0, g, 3'h2, 15'h0, 15'h0000);
            acc(1, 0, g, 3'h5, 15'h0, 15'h0000);
            acc(0, 1, g, 3'h0, v, 15'h0);
            acc(1, 0, g, 3'h0, 15'h0, 15'h0000);
            set_cond(g, v);
            acc(1, 0, g, 3'h0, 15'h0, v);
            acc(1, 0, g, 3'h0, 15'h0, v);
            chk_bit("summary masked", 1'b0, g ? quSummary : opSummary);
            acc(0, 1, g, 3'h1, v, 15'h0);
            repeat (3) @(posedge mclk);
            chk_bit("summary", 1'b1, g ? quSummary : opSummary);
            chk_val("rise pulses", 15'h0001, 15'(riseCnt[g]));
            acc(1, 0, g, 3'h1, 15'h0, v);
            acc(1, 0, g, 3'h2, 15'h0, v);
            repeat (2) @(posedge mclk);
            chk_bit("summary cleared", 1'b0, g ? quSummary : opSummary);
            acc(1, 0, g, 3'h2, 15'h0, 15'h0000);
            acc(0, 1, g, 3'h3, 15'h7FFF, 15'h0);
            acc(0, 1, g, 3'h4, 15'h0000, 15'h0);
            set_cond(g, 15'h0000);
            set_cond(g, v);
            acc(1, 0, g, 3'h2, 15'h0, v);
            // falling hit reaches the latch in the very cycle the latch is read
            @(posedge mclk);
            if (g)
                quCondIn <= 15'h0000;
            else
                opCondIn <= 15'h0000;
            @(posedge mclk);
            acc(1, 0, g, 3'h2, 15'h0, 15'h0000);
            acc(1, 0, g, 3'h2, 15'h0, v);
            acc(1, 0, g, 3'h3, 15'h0, 15'h7FFF);
            @(posedge mclk);
            presetReq <= 1'b1;
            @(posedge mclk);
            presetReq <= 1'b0;
            acc(1, 0, g, 3'h4, 15'h0, SER_ALL_ONES);
            acc(1, 0, g, 3'h3, 15'h0, 15'h0000);
            acc(1, 0, g, 3'h1, 15'h0, 15'h0000);
        end
        repeat (4) @(posedge mclk);
        chk_val("answers pending", 15'h0000, 15'(expQ.size()));
        tally_and_finish();
    end
endmodule
`default_nettype wire
